/* File: hw/trace_regs_pkg.sv */
// Summary of operation
// - control bit 0 turns tracing on when one, off when zero
// - clearing trace enable flushes all buffered packets to the output
// - enabling trace emits sync packets, or timestamp then core ratio
// - generation going active emits execution mode then gen enable packet
// - disabling emits only a gen disable packet if generation was active
// - changing control while tracing faults unless the write clears enable
// - bit 2 allows privilege zero, bit 3 allows privilege above zero
// - bit 7 turns page-table base filtering on
// - bit 8 selects table output; enabling with it clear faults
// - enabling trace with bit 13 clear faults
// - bit 10 turns timestamp packets on
// - bit 11 set turns return compression off
// - output tables may be cached while tracing; software disables first
// - a disabling write completes only after all packets are written
// - status writes fault while trace enable is set
// - device leaves status untouched while trace enable is zero
// - status bits 1 and 2 are device-set; writes to them are ignored
// - operational error sets bit 4, clears trigger, stops generation
// - table stop sets bit 5, clears trigger, stops generation
// - error and stopped are sticky, cleared by software when disabled
// - writing reserved bits of either register faults, except status bit 0, whose writes are ignored
package trace_regs_pkg;

  // register addresses
  localparam logic [31:0] CTL_ADDR = 32'h0000_0570;
  localparam logic [31:0] STS_ADDR = 32'h0000_0571;

  // control field positions
  localparam int CTL_TRACE_ON = 0;
  localparam int CTL_SUPV_ALLOW = 2;
  localparam int CTL_USER_ALLOW = 3;
  localparam int CTL_PAGE_FILTER = 7;
  localparam int CTL_TABLE_SCHEME = 8;
  localparam int CTL_TS_ON = 10;
  localparam int CTL_RET_OFF = 11;
  localparam int CTL_MUST_SET = 13;
  localparam logic [63:0] CTL_WR_MASK = 64'h0000_0000_0000_2d8d;
  localparam logic [63:0] CTL_RESET = 64'h0000_0000_0000_0000;

  // status field positions
  localparam int STS_CONTEXT = 1;
  localparam int STS_TRIGGER = 2;
  localparam int STS_ERROR = 4;
  localparam int STS_STOPPED = 5;
  localparam logic [63:0] STS_IGNORE_MASK = 64'h0000_0000_0000_0007;
  localparam logic [63:0] STS_WR_MASK = 64'h0000_0000_0000_0030;
  localparam logic [63:0] STS_RESET = 64'h0000_0000_0000_0000;

  // packet kinds requested from the encoder
  typedef enum logic [2:0] {
    pkt_none,
    pkt_sync_boundary,
    pkt_timestamp,
    pkt_core_ratio,
    pkt_exec_mode,
    pkt_gen_enable,
    pkt_gen_disable
  } pkt_kind_e;

  // register access phases
  typedef enum logic [1:0] {
    ph_idle,
    ph_answer,
    ph_flush
  } phase_e;

endpackage

/* File: hw/trace_packet_seq.sv */
`timescale 1ns/100ps
`default_nettype none
module trace_packet_seq (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // events from the register logic
  input wire logic trace_rise_i,
  input wire logic gen_rise_i,
  input wire logic gen_fall_i,
  input wire logic timestamp_packet_on_i,
  // packet request handshake
  output logic pkt_valid_o,
  output trace_regs_pkg::pkt_kind_e pkt_kind_o,
  input wire logic pkt_ready_i,
  output logic busy_o
);

  typedef struct packed {
    logic sync_pend;
    logic ts_pend;
    logic ratio_pend;
    logic mode_pend;
    logic pge_pend;
    logic pgd_pend;
  } seq_s;

  seq_s state;
  seq_s next_state;
  trace_regs_pkg::pkt_kind_e kind;

  // pick the pending packet by fixed priority, gen disable first, then emission order
  always_comb begin
    if (state.pgd_pend) begin
      kind = trace_regs_pkg::pkt_gen_disable;
    end else if (state.sync_pend) begin
      kind = trace_regs_pkg::pkt_sync_boundary;
    end else if (state.ts_pend) begin
      kind = trace_regs_pkg::pkt_timestamp;
    end else if (state.ratio_pend) begin
      kind = trace_regs_pkg::pkt_core_ratio;
    end else if (state.mode_pend) begin
      kind = trace_regs_pkg::pkt_exec_mode;
    end else if (state.pge_pend) begin
      kind = trace_regs_pkg::pkt_gen_enable;
    end else begin
      kind = trace_regs_pkg::pkt_none;
    end
  end

  assign pkt_valid_o = (kind != trace_regs_pkg::pkt_none);
  assign pkt_kind_o = kind;
  assign busy_o = pkt_valid_o;

  // clear the granted flag; new events set and win over the clear
  always_comb begin
    next_state = state;
    if (pkt_valid_o && pkt_ready_i) begin
      case (kind)
        trace_regs_pkg::pkt_gen_disable: next_state.pgd_pend = 1'b0;
        trace_regs_pkg::pkt_sync_boundary: next_state.sync_pend = 1'b0;
        trace_regs_pkg::pkt_timestamp: next_state.ts_pend = 1'b0;
        trace_regs_pkg::pkt_core_ratio: next_state.ratio_pend = 1'b0;
        trace_regs_pkg::pkt_exec_mode: next_state.mode_pend = 1'b0;
        trace_regs_pkg::pkt_gen_enable: next_state.pge_pend = 1'b0;
        default: next_state = state;
      endcase
    end
    if (trace_rise_i) begin
      if (timestamp_packet_on_i) begin
        next_state.ts_pend = 1'b1;
        next_state.ratio_pend = 1'b1;
      end else begin
        next_state.sync_pend = 1'b1;
      end
    end
    if (gen_rise_i) begin
      next_state.mode_pend = 1'b1;
      next_state.pge_pend = 1'b1;
    end
    if (gen_fall_i) begin
      next_state.pgd_pend = 1'b1;
      next_state.mode_pend = 1'b0;
      next_state.pge_pend = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule
`default_nettype wire

/* File: hw/trace_control_status_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module trace_control_status_regs (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // register access port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  output logic reg_ack_o,
  output logic protection_fault_o,
  output logic [63:0] reg_rdata_o,
  output logic reg_busy_o,
  // processor context
  input wire logic [1:0] privilege_level_i,
  input wire logic page_base_match_i,
  // trace engine events
  input wire logic op_error_i,
  input wire logic table_stop_i,
  input wire logic flush_done_i,
  // control outputs to the trace engine
  output logic trace_on_bit_o,
  output logic packet_gen_active_o,
  output logic output_table_scheme_o,
  output logic timestamp_packet_on_o,
  output logic return_compress_off_o,
  output logic page_base_filter_o,
  output logic flush_req_o,
  // packet requests
  output logic pkt_valid_o,
  output trace_regs_pkg::pkt_kind_e pkt_kind_o,
  input wire logic pkt_ready_i
);

  typedef struct packed {
    logic [63:0] ctl;
    logic [63:0] sts;
    logic [63:0] rdata;
    logic ack;
    logic fault;
    logic gen_prev;
    logic trace_prev;
    trace_regs_pkg::phase_e phase;
  } regs_s;

  regs_s state;
  regs_s next_state;
  logic ctl_wr;
  logic sts_wr;
  logic take;
  logic ctl_fault;
  logic sts_fault;
  logic filter_pass;
  logic gen_now;
  logic gen_rise;
  logic gen_fall;
  logic seq_busy;

  // control write legality check, used for the current write
  function automatic logic ctl_write_faults(input logic [63:0] cur,
                                            input logic [63:0] wr);
    logic bad;
    bad = 1'b0;
    if ((wr & ~trace_regs_pkg::CTL_WR_MASK) != 64'h0) begin
      bad = 1'b1;
    end
    if (cur[trace_regs_pkg::CTL_TRACE_ON] &&
        wr[trace_regs_pkg::CTL_TRACE_ON] && (wr != cur)) begin
      bad = 1'b1;
    end
    if (wr[trace_regs_pkg::CTL_TRACE_ON] &&
        !wr[trace_regs_pkg::CTL_TABLE_SCHEME]) begin
      bad = 1'b1;
    end
    if (wr[trace_regs_pkg::CTL_TRACE_ON] &&
        !wr[trace_regs_pkg::CTL_MUST_SET]) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // privilege and page-base filters for the current context
  function automatic logic context_ok(input logic [63:0] ctl,
                                      input logic [1:0] level,
                                      input logic page_match);
    logic lvl_ok;
    lvl_ok = (level == 2'h0) ? ctl[trace_regs_pkg::CTL_SUPV_ALLOW]
                             : ctl[trace_regs_pkg::CTL_USER_ALLOW];
    return lvl_ok &&
      (!ctl[trace_regs_pkg::CTL_PAGE_FILTER] || page_match);
  endfunction

  // request decode; a new request is taken only while idle
  assign take = (state.phase == trace_regs_pkg::ph_idle);
  assign ctl_wr = take && reg_wr_i &&
                  (reg_addr_i == trace_regs_pkg::CTL_ADDR);
  assign sts_wr = take && reg_wr_i &&
                  (reg_addr_i == trace_regs_pkg::STS_ADDR);
  assign ctl_fault = ctl_write_faults(state.ctl, reg_wdata_i);
  assign sts_fault = state.ctl[trace_regs_pkg::CTL_TRACE_ON] ||
    ((reg_wdata_i & ~(trace_regs_pkg::STS_WR_MASK |
                      trace_regs_pkg::STS_IGNORE_MASK)) != 64'h0);
  assign filter_pass = context_ok(state.ctl, privilege_level_i,
                                  page_base_match_i);

  // generation is active only with enable, trigger and context all set
  assign gen_now = state.ctl[trace_regs_pkg::CTL_TRACE_ON] &&
                   state.sts[trace_regs_pkg::STS_TRIGGER] &&
                   state.sts[trace_regs_pkg::STS_CONTEXT] &&
                   !state.sts[trace_regs_pkg::STS_ERROR] &&
                   !state.sts[trace_regs_pkg::STS_STOPPED];
  assign gen_rise = gen_now && !state.gen_prev;
  // no disable packet when an error or stop shut generation down
  assign gen_fall = !gen_now && state.gen_prev &&
                    !state.sts[trace_regs_pkg::STS_ERROR] &&
                    !state.sts[trace_regs_pkg::STS_STOPPED];

  // register updates, access answers and status tracking
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.fault = 1'b0;
    next_state.gen_prev = gen_now;
    next_state.trace_prev = state.ctl[trace_regs_pkg::CTL_TRACE_ON];
    case (state.phase)
      trace_regs_pkg::ph_idle: begin
        if (reg_wr_i || reg_rd_i) begin
          next_state.phase = trace_regs_pkg::ph_answer;
          next_state.rdata = 64'h0;
          if (reg_addr_i == trace_regs_pkg::CTL_ADDR) begin
            if (reg_rd_i) begin
              next_state.rdata = state.ctl;
            end else if (ctl_fault) begin
              next_state.fault = 1'b1;
            end else begin
              next_state.ctl = reg_wdata_i;
              if (state.ctl[trace_regs_pkg::CTL_TRACE_ON] &&
                  !reg_wdata_i[trace_regs_pkg::CTL_TRACE_ON]) begin
                next_state.phase = trace_regs_pkg::ph_flush;
              end
            end
          end else if (reg_addr_i == trace_regs_pkg::STS_ADDR) begin
            if (reg_rd_i) begin
              next_state.rdata = state.sts;
            end else if (sts_fault) begin
              next_state.fault = 1'b1;
            end else begin
              // context and trigger bits keep their value
              next_state.sts[trace_regs_pkg::STS_ERROR] =
                reg_wdata_i[trace_regs_pkg::STS_ERROR];
              next_state.sts[trace_regs_pkg::STS_STOPPED] =
                reg_wdata_i[trace_regs_pkg::STS_STOPPED];
            end
          end else begin
            next_state.fault = 1'b1; // unmapped register
          end
        end
      end
      trace_regs_pkg::ph_answer: begin
        next_state.ack = 1'b1;
        next_state.fault = state.fault;
        next_state.phase = trace_regs_pkg::ph_idle;
      end
      trace_regs_pkg::ph_flush: begin
        // hold the answer until packets are queued out and flushed
        if (flush_done_i && !seq_busy && !gen_fall) begin
          next_state.phase = trace_regs_pkg::ph_answer;
        end
      end
      default: begin
        next_state.phase = trace_regs_pkg::ph_idle;
      end
    endcase
    // device-side status tracking happens only while enabled
    if (state.ctl[trace_regs_pkg::CTL_TRACE_ON]) begin
      next_state.sts[trace_regs_pkg::STS_CONTEXT] = filter_pass;
      next_state.sts[trace_regs_pkg::STS_TRIGGER] =
        !state.sts[trace_regs_pkg::STS_ERROR] &&
        !state.sts[trace_regs_pkg::STS_STOPPED];
      if (op_error_i) begin
        next_state.sts[trace_regs_pkg::STS_ERROR] = 1'b1;
        next_state.sts[trace_regs_pkg::STS_TRIGGER] = 1'b0;
      end
      if (table_stop_i) begin
        next_state.sts[trace_regs_pkg::STS_STOPPED] = 1'b1;
        next_state.sts[trace_regs_pkg::STS_TRIGGER] = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state.ctl <= trace_regs_pkg::CTL_RESET;
      state.sts <= trace_regs_pkg::STS_RESET;
      state.rdata <= 64'h0;
      state.ack <= 1'b0;
      state.fault <= 1'b0;
      state.gen_prev <= 1'b0;
      state.trace_prev <= 1'b0;
      state.phase <= trace_regs_pkg::ph_idle;
    end else begin
      state <= next_state;
    end
  end

  // packet request sequencer
  trace_packet_seq u_seq (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .trace_rise_i(state.ctl[trace_regs_pkg::CTL_TRACE_ON] &&
                  !state.trace_prev),
    .gen_rise_i(gen_rise),
    .gen_fall_i(gen_fall),
    .timestamp_packet_on_i(state.ctl[trace_regs_pkg::CTL_TS_ON]),
    .pkt_valid_o(pkt_valid_o),
    .pkt_kind_o(pkt_kind_o),
    .pkt_ready_i(pkt_ready_i),
    .busy_o(seq_busy)
  );

  // outputs
  assign reg_ack_o = state.ack;
  assign protection_fault_o = state.ack && state.fault;
  assign reg_rdata_o = state.rdata;
  assign reg_busy_o = !take;
  assign trace_on_bit_o = state.ctl[trace_regs_pkg::CTL_TRACE_ON];
  assign packet_gen_active_o = gen_now;
  assign output_table_scheme_o = state.ctl[trace_regs_pkg::CTL_TABLE_SCHEME];
  assign timestamp_packet_on_o = state.ctl[trace_regs_pkg::CTL_TS_ON];
  assign return_compress_off_o = state.ctl[trace_regs_pkg::CTL_RET_OFF];
  assign page_base_filter_o = state.ctl[trace_regs_pkg::CTL_PAGE_FILTER];
  assign flush_req_o = (state.phase == trace_regs_pkg::ph_flush);

endmodule
`default_nettype wire

/* File: testbench/trace_regs_props.sv */
`timescale 1ns/100ps
`default_nettype none
module trace_regs_props (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic reg_busy_o,
  input wire logic reg_ack_o,
  input wire logic protection_fault_o,
  // engine side
  input wire logic op_error_i,
  input wire logic flush_done_i,
  input wire logic flush_req_o,
  input wire logic trace_on_bit_o,
  input wire logic packet_gen_active_o,
  input wire logic output_table_scheme_o,
  input wire logic timestamp_packet_on_o,
  input wire logic return_compress_off_o,
  input wire logic page_base_filter_o,
  input wire logic pkt_valid_o,
  input wire trace_regs_pkg::pkt_kind_e pkt_kind_o,
  input wire logic pkt_ready_i
);
  // single clock domain
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // an error taken while tracing runs
  sequence s_err;
    trace_on_bit_o && op_error_i;
  endsequence
  // a write taken while tracing is off
  sequence s_off_write;
    !reg_busy_o && reg_wr_i && !trace_on_bit_o;
  endsequence
  a_fault_with_ack: assert property (
    protection_fault_o |-> reg_ack_o) else $error("fault without ack");
  a_off_write_ack: assert property (
    s_off_write |-> ##2 reg_ack_o) else $error("write ack late");
  a_gen_needs_on: assert property (
    packet_gen_active_o |-> trace_on_bit_o) else $error("gen while off");
  a_pkt_held: assert property (
    pkt_valid_o && !pkt_ready_i |=> pkt_valid_o && $stable(pkt_kind_o))
    else $error("packet request dropped");
  a_error_stops_gen: assert property (
    s_err |-> ##[1:2] !packet_gen_active_o) else $error("gen after error");
  a_flush_holds: assert property (
    flush_req_o && !flush_done_i |=> flush_req_o) else $error("flush cut");
  a_no_early_ack: assert property (
    flush_req_o && !flush_done_i |-> !reg_ack_o) else $error("ack in flush");
  a_cfg_locked: assert property (
    $past(trace_on_bit_o) && trace_on_bit_o |-> $stable({page_base_filter_o,
    output_table_scheme_o, timestamp_packet_on_o, return_compress_off_o}))
    else $error("config changed while on");
  a_enable_table: assert property (
    $rose(trace_on_bit_o) |-> output_table_scheme_o)
    else $error("enabled without table");
  a_off_flushes: assert property (
    $fell(trace_on_bit_o) |-> ##[0:1] flush_req_o) else $error("no flush");
endmodule
`default_nettype wire

/* File: testbench/trace_control_status_regs_test.sv */
`timescale 1ns/100ps
`default_nettype none
module trace_control_status_regs_test;
  localparam logic [31:0] CTL = trace_regs_pkg::CTL_ADDR;
  localparam logic [31:0] STS = trace_regs_pkg::STS_ADDR;
  localparam logic [11:0] SEQ_ON = {3'h0, trace_regs_pkg::pkt_sync_boundary,
    trace_regs_pkg::pkt_exec_mode, trace_regs_pkg::pkt_gen_enable};
  localparam logic [11:0] SEQ_TS = {trace_regs_pkg::pkt_timestamp,
    trace_regs_pkg::pkt_core_ratio, trace_regs_pkg::pkt_exec_mode,
    trace_regs_pkg::pkt_gen_enable};
  // design inputs
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_addr_i = '0;
  logic [63:0] reg_wdata_i = '0;
  logic [1:0] privilege_level_i = 2'h0;
  logic page_base_match_i = 1'b1;
  logic op_error_i = 1'b0;
  logic table_stop_i = 1'b0;
  logic flush_done_i = 1'b0;
  logic pkt_ready_i = 1'b1;
  // design outputs
  logic reg_ack_o, protection_fault_o, reg_busy_o, trace_on_bit_o;
  logic packet_gen_active_o, output_table_scheme_o, timestamp_packet_on_o;
  logic return_compress_off_o, page_base_filter_o, flush_req_o, pkt_valid_o;
  logic [63:0] reg_rdata_o;
  trace_regs_pkg::pkt_kind_e pkt_kind_o;
  // bench state
  logic [11:0] pkt_hist = '0;
  int pkt_cnt = 0;
  int flush_cnt = 0;
  int errors = 0;
  int compares = 0;
  int last_n;
  logic last_f;
  logic [63:0] last_q;

  // core clock
  always #20 clock_i = ~clock_i;

  trace_control_status_regs u_dut (.clock_i, .arst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o, .protection_fault_o,
    .reg_rdata_o, .reg_busy_o, .privilege_level_i, .page_base_match_i,
    .op_error_i, .table_stop_i, .flush_done_i, .trace_on_bit_o,
    .packet_gen_active_o, .output_table_scheme_o, .timestamp_packet_on_o,
    .return_compress_off_o, .page_base_filter_o, .flush_req_o, .pkt_valid_o,
    .pkt_kind_o, .pkt_ready_i);

  // log accepted packets; engine answers a flush after a few cycles
  always @(posedge clock_i) begin
    if (pkt_valid_o && pkt_ready_i) begin
      pkt_hist <= {pkt_hist[8:0], pkt_kind_o};
      pkt_cnt <= pkt_cnt + 1;
    end
    flush_cnt <= flush_req_o ? flush_cnt + 1 : 0;
    flush_done_i <= flush_req_o && flush_cnt >= 5;
  end

  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one register access: request for one edge, wait for the answer
  task automatic acc(input logic w, input logic [31:0] a, input logic [63:0] d);
    @(posedge clock_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    last_n = 0;
    do begin
      @(posedge clock_i);
      #1;
      last_n++;
    end while (!reg_ack_o && last_n < 40);
    if (reg_ack_o !== 1'b1) begin
      errors++;
      $display("[ERR] %0t no ack got %h exp %h", $time, reg_ack_o, 1'b1);
      summarize();
    end
    last_f = protection_fault_o;
    last_q = reg_rdata_o;
  endtask

  task automatic wr(input logic [31:0] a, input logic [63:0] d, input logic f);
    acc(1'b1, a, d);
    chk(64'(last_f), 64'(f));
  endtask

  task automatic rd(input logic [31:0] a, input logic [63:0] m,
    input logic [63:0] e);
    acc(1'b0, a, '0);
    chk(last_q & m, e);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic t_reset();
    rd(CTL, '1, '0);
    rd(STS, '1, '0);
    chk(64'({trace_on_bit_o, pkt_valid_o, flush_req_o}), '0);
  endtask

  task automatic t_fields();
    wr(CTL, 64'h2d8c, 1'b0);
    chk(64'({page_base_filter_o, output_table_scheme_o,
      timestamp_packet_on_o, return_compress_off_o}), 64'hf);
    wr(CTL, 64'h2d8e, 1'b1);
    wr(CTL, 64'h6d8c, 1'b1);
    wr(STS, 64'h8, 1'b1);
    wr(CTL + 32'h2, 64'h0, 1'b1);
    wr(CTL, 64'h2001, 1'b1);
    wr(CTL, 64'h0101, 1'b1);
    rd(CTL, '1, 64'h2d8c);
    wr(CTL, '0, 1'b0);
    chk(64'(return_compress_off_o), '0);
  endtask

  // enable at a blocked privilege level with the encoder stalled
  task automatic t_enable();
    @(posedge clock_i);
    privilege_level_i <= 2'h1;
    pkt_ready_i <= 1'b0;
    pkt_hist = '0;
    pkt_cnt = 0;
    wr(CTL, 64'h2105, 1'b0);
    idle(8);
    chk(64'(packet_gen_active_o), '0);
    chk(64'(pkt_valid_o), 64'h1);
    @(posedge clock_i);
    privilege_level_i <= 2'h0;
    pkt_ready_i <= 1'b1;
    idle(10);
    chk(64'(packet_gen_active_o), 64'h1);
    chk(64'(pkt_hist), 64'(SEQ_ON));
  endtask

  task automatic t_locked();
    wr(CTL, 64'h2505, 1'b1);
    wr(CTL, 64'h2105, 1'b0);
    wr(STS, '0, 1'b1);
    rd(CTL, '1, 64'h2105);
    pkt_hist = '0;
    wr(CTL, '0, 1'b0);
    chk(64'(last_n > 5), 64'h1);
    chk(64'(pkt_hist), 64'(trace_regs_pkg::pkt_gen_disable));
  endtask

  // error or table stop, then sticky status handling while off
  task automatic t_sticky(input logic stop);
    logic [63:0] prior_sts;
    pkt_hist = '0;
    wr(CTL, stop ? 64'h2105 : 64'h2505, 1'b0);
    idle(12);
    if (!stop) chk(64'(pkt_hist), 64'(SEQ_TS));
    @(posedge clock_i);
    op_error_i <= !stop;
    table_stop_i <= stop;
    @(posedge clock_i);
    op_error_i <= 1'b0;
    table_stop_i <= 1'b0;
    idle(3);
    chk(64'(packet_gen_active_o), '0);
    rd(STS, 64'h34, stop ? 64'h20 : 64'h10);
    pkt_cnt = 0;
    wr(CTL, '0, 1'b0);
    chk(64'(pkt_cnt), '0);
    acc(1'b0, STS, '0);
    prior_sts = last_q;
    idle(10);
    rd(STS, '1, prior_sts);
    wr(STS, 64'h26, 1'b0);
    rd(STS, 64'h36, (prior_sts & 64'h6) | 64'h20);
    wr(STS, '0, 1'b0);
    rd(STS, 64'h30, '0);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_fields();
    t_enable();
    t_locked();
    t_sticky(1'b0);
    t_sticky(1'b1);
    summarize();
  end
endmodule

bind trace_control_status_regs trace_regs_props u_props (.clock_i,
  .arst_n_i, .reg_wr_i, .reg_busy_o, .reg_ack_o, .protection_fault_o,
  .op_error_i, .flush_done_i, .flush_req_o, .trace_on_bit_o,
  .packet_gen_active_o, .output_table_scheme_o, .timestamp_packet_on_o,
  .return_compress_off_o, .page_base_filter_o, .pkt_valid_o, .pkt_kind_o,
  .pkt_ready_i);
`default_nettype wire
